// [ssw_top.sv]
// Supply supervisor with watchdog, backup switchover and chip enable gating.
module ssw_top
    import ssw_pkg::*;
#(
    parameter int unsigned WD_FAST_LIM = WD_FAST_CYC,
    parameter int unsigned WD_SLOW_LIM = WD_SLOW_CYC,
    parameter int unsigned RST_LIM     = RST_CYC
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic supply_low_in,
    input  wire logic supply_below_backup_in,
    input  wire logic kick_hi_in,
    input  wire logic kick_lo_in,
    input  wire logic timing_source_select,
    input  wire logic timing_source_in,
    input  wire logic powerfail_monitor_in,
    input  wire logic ce_in_n,
    output logic      low_line_n,
    output logic      reset_n,
    output logic      reset_hi,
    output logic      kick_fault_out_n,
    output logic      backup_in_use_flag,
    output logic      powerfail_flag_out_n,
    output logic      ce_out_n
);

    // ==========================================================
    // Input synchronisation
    ssw_pins_t pins_raw;
    ssw_pins_t pins;

    always_comb begin
        pins_raw.supply_low   = supply_low_in;
        pins_raw.below_backup = supply_below_backup_in;
        pins_raw.kick_hi      = kick_hi_in;
        pins_raw.kick_lo      = kick_lo_in;
        pins_raw.ts_select    = timing_source_select;
        pins_raw.ts_in        = timing_source_in;
        pins_raw.pf_ok        = powerfail_monitor_in;
        pins_raw.ce_in_n      = ce_in_n;
    end

    ssw_sync #(
        .W     (PINS_W),
        .RST_V (PINS_RESET)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .sync_out (pins)
    );

    // ==========================================================
    // State
    ssw_state_t  state_q,     state_d;
    logic [31:0] rst_cnt_q,   rst_cnt_d;
    logic [31:0] wd_cnt_q,    wd_cnt_d;
    logic        first_q,     first_d;
    logic        fault_q,     fault_d;
    logic        kick_lvl_q,  kick_lvl_d;
    logic        ts_prev_q,   ts_prev_d;
    logic        backup_q,    backup_d;
    logic        ce_hold_q,   ce_hold_d;
    logic [31:0] ce_cnt_q,    ce_cnt_d;
    logic        ce_out_q,    ce_out_d;
    logic        rst_n_q,     rst_n_d;
    logic        low_line_q,  low_line_d;
    logic        pf_q,        pf_d;

    logic        tick;
    logic        kick_mid;
    logic        kick_edge;
    logic        wd_enable;
    logic [31:0] wd_lim;
    logic [31:0] rst_lim;
    logic        rst_active;
    logic        rst_active_d;

    // ==========================================================
    // Timebase selection
    always_comb begin
        tick = pins.ts_select ? 1'b1 : (pins.ts_in & ~ts_prev_q);
        ts_prev_d = pins.ts_in;
        if (!pins.ts_select) begin
            wd_lim  = first_q ? EXT_FIRST_CLKS : EXT_WD_CLKS;
            rst_lim = EXT_RST_CLKS;
        end else begin
            if (first_q || pins.ts_in) begin
                wd_lim = WD_SLOW_LIM;
            end else begin
                wd_lim = WD_FAST_LIM;
            end
            rst_lim = RST_LIM;
        end
    end

    // ==========================================================
    // Backup switchover
    always_comb begin
        backup_d = backup_q;
        if (pins.below_backup && pins.supply_low) begin
            backup_d = 1'b1;
        end else if (!pins.below_backup && !pins.supply_low) begin
            backup_d = 1'b0;
        end
    end

    // ==========================================================
    // Kick decode, watchdog and reset sequencer
    always_comb begin
        kick_mid   = ~pins.kick_hi & ~pins.kick_lo;
        kick_edge  = ~kick_mid & (pins.kick_hi != kick_lvl_q);
        kick_lvl_d = kick_mid ? kick_lvl_q : pins.kick_hi;
        wd_enable  = ~kick_mid & ~pins.supply_low & ~backup_q;

        state_d   = state_q;
        rst_cnt_d = rst_cnt_q;
        wd_cnt_d  = wd_cnt_q;
        first_d   = first_q;
        fault_d   = fault_q;

        if (kick_edge || !wd_enable) begin
            fault_d = 1'b0;
        end

        unique case (state_q)
            ST_SUPPLY_LOW: begin
                rst_cnt_d = '0;
                if (!pins.supply_low) begin
                    state_d = ST_RST_TIMEOUT;
                end
            end
            ST_RST_TIMEOUT: begin
                if (pins.supply_low) begin
                    state_d = ST_SUPPLY_LOW;
                end else if (tick) begin
                    if (rst_cnt_q + 32'h1 >= rst_lim) begin
                        state_d = ST_RUN;
                        wd_cnt_d = '0;
                    end
                    rst_cnt_d = rst_cnt_q + 32'h1;
                end
            end
            ST_RUN: begin
                if (pins.supply_low) begin
                    state_d = ST_SUPPLY_LOW;
                    first_d = 1'b1;
                end else if (!wd_enable || kick_edge) begin
                    wd_cnt_d = '0;
                    if (kick_edge) begin
                        first_d = 1'b0;
                    end
                end else if (tick) begin
                    wd_cnt_d = wd_cnt_q + 32'h1;
                    if (wd_cnt_q + 32'h1 >= wd_lim) begin
                        fault_d   = 1'b1;
                        state_d   = ST_RST_TIMEOUT;
                        rst_cnt_d = '0;
                        first_d   = 1'b1;
                    end
                end
            end
        endcase

        if (state_d == ST_SUPPLY_LOW) begin
            first_d = 1'b1;
        end
    end

    // ==========================================================
    // Chip enable gating and outputs
    always_comb begin
        rst_active   = (state_q != ST_RUN);
        rst_active_d = (state_d != ST_RUN);
        ce_hold_d    = ce_hold_q;
        ce_cnt_d     = ce_cnt_q;
        if (rst_active_d && !rst_active && !pins.ce_in_n) begin
            ce_hold_d = 1'b1;
            ce_cnt_d  = '0;
        end else if (ce_hold_q) begin
            ce_cnt_d = ce_cnt_q + 32'h1;
            if (pins.ce_in_n || ce_cnt_q + 32'h1 >= CE_HOLD_CYC
                    || !rst_active_d) begin
                ce_hold_d = 1'b0;
            end
        end
        ce_out_d   = pins.ce_in_n | (rst_active_d & ~ce_hold_d);
        rst_n_d    = ~rst_active_d;
        low_line_d = ~pins.supply_low;
        pf_d       = pins.pf_ok;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q    <= ST_SUPPLY_LOW;
            rst_cnt_q  <= '0;
            wd_cnt_q   <= '0;
            first_q    <= 1'b1;
            fault_q    <= 1'b0;
            kick_lvl_q <= 1'b0;
            ts_prev_q  <= 1'b1;
            backup_q   <= 1'b0;
            ce_hold_q  <= 1'b0;
            ce_cnt_q   <= '0;
            ce_out_q   <= 1'b1;
            rst_n_q    <= 1'b0;
            low_line_q <= 1'b0;
            pf_q       <= 1'b0;
        end else begin
            state_q    <= state_d;
            rst_cnt_q  <= rst_cnt_d;
            wd_cnt_q   <= wd_cnt_d;
            first_q    <= first_d;
            fault_q    <= fault_d;
            kick_lvl_q <= kick_lvl_d;
            ts_prev_q  <= ts_prev_d;
            backup_q   <= backup_d;
            ce_hold_q  <= ce_hold_d;
            ce_cnt_q   <= ce_cnt_d;
            ce_out_q   <= ce_out_d;
            rst_n_q    <= rst_n_d;
            low_line_q <= low_line_d;
            pf_q       <= pf_d;
        end
    end

    assign low_line_n           = low_line_q;
    assign reset_n              = rst_n_q;
    assign reset_hi             = ~rst_n_q;
    assign kick_fault_out_n     = ~fault_q;
    assign backup_in_use_flag   = backup_q;
    assign powerfail_flag_out_n = pf_q;
    assign ce_out_n             = ce_out_q;

endmodule : ssw_top

// [ssw_pkg.sv]
// Constants, carrier types and state codes of the supply supervisor watchdog.
package ssw_pkg;

    // ==========================================================
    // Timing
    localparam real         CLK_HZ        = 125.0e6;
    localparam real         T_WD_FAST_MS  = 100.0;
    localparam real         T_WD_SLOW_S   = 1.6;
    localparam real         T_RST_MS      = 200.0;
    localparam real         T_CE_HOLD_US  = 15.0;
    // Counts round to the nearest cycle, so float error cannot drop one.
    localparam int unsigned WD_FAST_CYC   =
        int'(T_WD_FAST_MS * 1.0e-3 * CLK_HZ);
    localparam int unsigned WD_SLOW_CYC   = int'(T_WD_SLOW_S * CLK_HZ);
    localparam int unsigned RST_CYC       = int'(T_RST_MS * 1.0e-3 * CLK_HZ);
    localparam int unsigned CE_HOLD_CYC   =
        int'(T_CE_HOLD_US * 1.0e-6 * CLK_HZ);
    localparam int unsigned EXT_WD_CLKS   = 1024;
    localparam int unsigned EXT_FIRST_CLKS = 4096;
    localparam int unsigned EXT_RST_CLKS  = 2048;

    // ==========================================================
    // Pin bundle and its reset value
    typedef struct packed {
        logic supply_low;     // Main supply below reset threshold.
        logic below_backup;   // Main supply below backup supply level.
        logic kick_hi;        // Kick input above its high threshold.
        logic kick_lo;        // Kick input below its low threshold.
        logic ts_select;      // Timing source select, high for internal.
        logic ts_in;          // Timing source input level.
        logic pf_ok;          // Monitor input above the power-fail level.
        logic ce_in_n;        // Chip enable input, active low.
    } ssw_pins_t;

    localparam int        PINS_W     = $bits(ssw_pins_t);
    localparam ssw_pins_t PINS_RESET = 8'h8D;

    // ==========================================================
    // Reset sequencer states
    typedef enum logic [2:0] {
        ST_SUPPLY_LOW  = 3'h1,
        ST_RST_TIMEOUT = 3'h2,
        ST_RUN         = 3'h4
    } ssw_state_t;

endpackage : ssw_pkg

// [ssw_sync.sv]
// Three-stage input synchroniser that accepts a change once stages agree.
module ssw_sync #(
    parameter int             W     = 1,
    parameter logic [W-1:0]   RST_V = '0
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_d;
    logic [W-1:0] out_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
            end
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    s1_q[i]  <= RST_V[i];
                    s2_q[i]  <= RST_V[i];
                    s3_q[i]  <= RST_V[i];
                    out_q[i] <= RST_V[i];
                end else begin
                    s1_q[i]  <= async_in[i];
                    s2_q[i]  <= s1_q[i];
                    s3_q[i]  <= s2_q[i];
                    out_q[i] <= out_d[i];
                end
            end
        end
    endgenerate

    assign sync_out = out_q;

endmodule : ssw_sync

// [ssw_props.sv]
// Concurrent checks on the supervisor top ports.
module ssw_props
    import ssw_pkg::*;
#(
    parameter int unsigned RST_LIM = RST_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic supply_low_in,
    input wire logic supply_below_backup_in,
    input wire logic kick_hi_in,
    input wire logic kick_lo_in,
    input wire logic ce_in_n,
    input wire logic low_line_n,
    input wire logic reset_n,
    input wire logic reset_hi,
    input wire logic kick_fault_out_n,
    input wire logic backup_in_use_flag,
    input wire logic ce_out_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ====================
    // Helper count of reset low cycles
    logic [31:0] lo_q;
    always_ff @(posedge clock) begin
        lo_q <= (!rst_n || reset_n) ? 32'h0 : lo_q + 32'h1;
    end
    // Seven samples cover the input synchroniser latency.
    sequence s_low; supply_low_in [*7]; endsequence
    sequence s_up; !supply_low_in [*7]; endsequence
    sequence s_rst_pulse; !reset_n [*8]; endsequence
    // ====================
    // Properties
    a_reset_inverse:
    assert property (reset_hi == !reset_n) else $error("reset_hi bad");
    a_low_line_down:
    assert property (s_low |-> !low_line_n) else $error("low line high");
    a_low_line_up:
    assert property (s_up |-> low_line_n) else $error("low line stuck");
    a_reset_on_low:
    assert property (s_low |-> !reset_n) else $error("reset not held");
    a_fault_off_low:
    assert property (s_low |-> kick_fault_out_n) else $error("fault low");
    a_fault_off_mid:
    assert property ((!kick_hi_in && !kick_lo_in) [*7] |-> kick_fault_out_n)
        else $error("fault while kick floats");
    a_ce_gate_off:
    assert property (ce_in_n [*7] |-> ce_out_n) else $error("ce passed");
    a_backup_in_use:
    assert property ((supply_low_in && supply_below_backup_in) [*7]
        |-> backup_in_use_flag) else $error("backup flag low");
    a_fault_gives_reset:
    assert property ($fell(kick_fault_out_n) |-> ##[0:1] s_rst_pulse)
        else $error("fault without reset");
    a_reset_long_enough:
    assert property ($rose(reset_n) |-> lo_q >= RST_LIM)
        else $error("reset pulse short");
endmodule : ssw_props

bind ssw_top ssw_props #(.RST_LIM(RST_LIM)) u_props (
    .clock(clock), .rst_n(rst_n), .supply_low_in(supply_low_in),
    .supply_below_backup_in(supply_below_backup_in),
    .kick_hi_in(kick_hi_in), .kick_lo_in(kick_lo_in), .ce_in_n(ce_in_n),
    .low_line_n(low_line_n), .reset_n(reset_n), .reset_hi(reset_hi),
    .kick_fault_out_n(kick_fault_out_n),
    .backup_in_use_flag(backup_in_use_flag), .ce_out_n(ce_out_n));

// [ssw_cpu_model.sv]
// Processor model: toggles the kick line, may stall or float it.
module ssw_cpu_model
    import ssw_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        float_kick,
    input  wire logic [15:0] gap,
    output logic             kick_hi,
    output logic             kick_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q = 16'h0000;
    logic        lvl_q = 1'b0;
    always @(posedge clock) begin
        if (!reset_n || gap == 16'h0000) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q + 16'h0001 >= gap) begin
            cnt_q <= 16'h0000;
            lvl_q <= !lvl_q;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
    assign kick_hi = !float_kick && lvl_q;
    assign kick_lo = !float_kick && !lvl_q;
endmodule : ssw_cpu_model

// [ssw_top_bench.sv]
// Self-checking bench for the supervisor top.
module ssw_top_bench import ssw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FAST = 50;
    localparam int SLOW = 200;
    localparam int RL   = 30;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    ssw_pins_t   pins = 8'h8B;
    logic        float_kick = 1'b0;
    logic        ext_run = 1'b0;
    logic [15:0] gap = 16'h0014;
    logic [2:0]  div = 3'h0;
    logic        kick_hi, kick_lo, low_line_n, reset_n, reset_hi;
    logic        fault_n, bk, pf_n, ce_out_n;
    int          fail_count = 0;
    int          comparisons = 0;
    ssw_top #(.WD_FAST_LIM(FAST), .WD_SLOW_LIM(SLOW), .RST_LIM(RL)) u_dut (
        .clock(clock), .rst_n(rst_n), .supply_low_in(pins.supply_low),
        .supply_below_backup_in(pins.below_backup), .kick_hi_in(kick_hi),
        .kick_lo_in(kick_lo), .timing_source_select(pins.ts_select),
        .timing_source_in(ext_run ? div[2] : pins.ts_in),
        .powerfail_monitor_in(pins.pf_ok),
        .ce_in_n(pins.ce_in_n), .low_line_n(low_line_n), .reset_n(reset_n),
        .reset_hi(reset_hi), .kick_fault_out_n(fault_n),
        .backup_in_use_flag(bk), .powerfail_flag_out_n(pf_n),
        .ce_out_n(ce_out_n));
    ssw_cpu_model u_cpu (.clock(clock), .reset_n(reset_n),
        .float_kick(float_kick), .gap(gap), .kick_hi(kick_hi),
        .kick_lo(kick_lo));
    always #4 clock = ~clock;
    // Timing clock of eight cycles, slow enough to pass the synchroniser.
    always @(posedge clock) begin
        if (ext_run) begin
            div <= div + 3'h1;
        end
    end
    // ====================
    // Helpers
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(negedge clock);
    endtask : cyc
    function automatic logic pick(input int w);
        return w == 0 ? reset_n : (w == 1 ? fault_n : ce_out_n);
    endfunction : pick
    task automatic wait_out(input int w, input logic v, input int lim,
                            output int n);
        n = 0;
        @(negedge clock);
        while (pick(w) !== v && n < lim) begin
            @(negedge clock);
            n++;
        end
        chk("wait_out", {31'h0, v}, {31'h0, pick(w)});
    endtask : wait_out
    task automatic quiet(input int c, input string nm);
        logic bad = 1'b0;
        repeat (c) begin
            @(negedge clock);
            bad |= (reset_n !== 1'b1) || (fault_n !== 1'b1);
        end
        chk(nm, 0, bad);
    endtask : quiet
    task automatic end_of_test();
        if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // ====================
    // Scenarios
    task automatic t_power_up();
        int n;
        @(posedge clock);
        pins.supply_low <= 1'b0;
        cyc(8);
        chk("low_line_n", 1, low_line_n);
        chk("reset_n", 0, reset_n);
        chk("reset_hi", 1, reset_hi);
        wait_out(0, 1'b1, RL + 20, n);
        chk("rst_len", 1, n + 8 >= RL && n + 8 <= RL + 10);
    endtask : t_power_up
    task automatic t_stuck();
        int n;
        @(posedge clock);
        gap <= 16'h0000;
        wait_out(1, 1'b0, FAST + 20, n);
        chk("wd_fast", 1, n >= FAST - 25);
        chk("wd_reset", 0, reset_n);
        wait_out(0, 1'b1, RL + 10, n);
        chk("fault_hold", 0, fault_n);
        wait_out(0, 1'b0, SLOW + 20, n);
        chk("wd_slow", 1, n >= SLOW - 5);
        wait_out(0, 1'b1, RL + 10, n);
        @(posedge clock);
        gap <= 16'h0014;
        wait_out(1, 1'b1, 40, n);
    endtask : t_stuck
    task automatic t_slow_mid();
        @(posedge clock);
        pins.ts_in <= 1'b1;
        gap <= 16'h0000;
        quiet(150, "slow_only");
        @(posedge clock);
        gap <= 16'h0014;
        cyc(30);
        @(posedge clock);
        float_kick <= 1'b1;
        gap <= 16'h0000;
        quiet(300, "mid_off");
        @(posedge clock);
        float_kick <= 1'b0;
        gap <= 16'h0014;
        pins.ts_in <= 1'b0;
    endtask : t_slow_mid
    task automatic t_ext();
        int n;
        @(posedge clock);
        ext_run <= 1'b1;
        pins.ts_select <= 1'b0;
        cyc(100);
        @(posedge clock);
        gap <= 16'h0000;
        wait_out(1, 1'b0, EXT_WD_CLKS * 8 + 200, n);
        chk("ext_wd", 1, n >= EXT_WD_CLKS * 8 - 200);
        wait_out(0, 1'b1, EXT_RST_CLKS * 8 + 200, n);
        chk("ext_rst", 1, n >= EXT_RST_CLKS * 8 - 100);
        @(posedge clock);
        ext_run <= 1'b0;
        pins.ts_select <= 1'b1;
        gap <= 16'h0014;
        wait_out(1, 1'b1, 60, n);
    endtask : t_ext
    task automatic t_ce();
        int n;
        @(posedge clock);
        pins.ce_in_n <= 1'b0;
        cyc(8);
        chk("ce_pass", 0, ce_out_n);
        @(posedge clock);
        pins.supply_low <= 1'b1;
        cyc(8);
        chk("ce_hold", 0, ce_out_n);
        wait_out(2, 1'b1, CE_HOLD_CYC + 20, n);
        chk("ce_15us", 1, n >= CE_HOLD_CYC - 20);
        @(posedge clock);
        pins.ce_in_n <= 1'b1;
        pins.supply_low <= 1'b0;
        wait_out(0, 1'b1, RL + 20, n);
        @(posedge clock);
        pins.ce_in_n <= 1'b0;
        pins.supply_low <= 1'b1;
        cyc(10);
        @(posedge clock);
        pins.ce_in_n <= 1'b1;
        cyc(8);
        chk("ce_early", 1, ce_out_n);
    endtask : t_ce
    task automatic t_supply();
        int n;
        @(posedge clock);
        pins.below_backup <= 1'b1;
        cyc(8);
        chk("bk_on", 1, bk);
        chk("wd_off", 1, fault_n);
        @(posedge clock);
        pins.below_backup <= 1'b0;
        pins.supply_low <= 1'b0;
        pins.pf_ok <= 1'b0;
        cyc(8);
        chk("bk_off", 0, bk);
        chk("pf_low", 0, pf_n);
        @(posedge clock);
        pins.supply_low <= 1'b1;
        cyc(6);
        @(posedge clock);
        pins.supply_low <= 1'b0;
        wait_out(0, 1'b1, RL + 20, n);
        chk("rst_restart", 1, n >= RL);
        @(posedge clock);
        pins.pf_ok <= 1'b1;
        cyc(8);
        chk("pf_high", 1, pf_n);
    endtask : t_supply
    // ====================
    // Main sequence and watchdog
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_power_up();
        quiet(300, "kick_ok");
        t_stuck();
        t_slow_mid();
        t_ext();
        t_ce();
        t_supply();
        end_of_test();
    end
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        end_of_test();
    end
endmodule : ssw_top_bench
